// file: core/scs_spi.v
// SPI master with per-select timing configuration and an Avalon-MM slave.
// Assumes miso is asynchronous to core_clk; the bus master is synchronous.
// How it works
// RULE1 - Nonzero consecutive delay waits 32 times field clocks after each transfer.
// RULE2 - Zero consecutive delay means no gap and continuous clock between characters.
// RULE3 - Select-to-first-edge equals pre-clock field clocks, or half clock if zero.
// RULE4 - Serial clock is module clock divided by baud divider, 1 to 255; a divider of 1 gives the module clock divided by 2.
// RULE5 - Divider resets to zero; software must program nonzero before transfers.
// RULE6 - Mixing divider one with others not one breaks other selects.
// RULE7 - Width codes 0-8 give 8-16 bits, 9-12 give 4-7; rest reserved.
// RULE8 - Hold-active keeps select low until a transfer on another select.
// RULE9 - Without hold-active, select rises when the last transfer completes.
// RULE10 - Without forced release, select stays low if next word queued in time.
// RULE11 - Forced release raises select between transfers for inter-select delay (+1).
// RULE12 - Phase one samples on leading edge, changes on trailing edge.
// RULE13 - Phase zero changes on leading edge, samples on trailing edge.
// RULE14 - Serial clock idles at the polarity bit level.
// RULE15 - Each config register is 32-bit read/write with the documented field layout.
// RULE16 - Each transfer uses the config of its selected chip select.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_spi #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire core_clk, // 200 MHz clock
	input wire sys_rst, // Sync reset, high
	input wire [7:0] avs_address, // Byte address
	input wire avs_read, // Read strobe
	input wire avs_write, // Write strobe
	input wire [31:0] avs_writedata, // Write data
	input wire [3:0] avs_byteenable, // Byte lanes
	output reg [31:0] avs_readdata, // Read data
	output wire avs_waitrequest, // Stall
	output reg serial_clock, // Serial clock
	output reg mosi, // Data out
	input wire miso, // Data in
	output reg [1:0] peripheral_select_line_n // Selects, low active
);
	// ******************************
	// Register file and bus slave
	// ******************************
	reg [31:0] cfg_r [0:1];
	reg [7:0] isd_r;
	reg [15:0] rx_data_r;
	reg rx_new_r;
	reg ack_r;
	wire sel_c1 = (avs_address == `SCS_OFS_CFG1);
	wire sel_c2 = (avs_address == `SCS_OFS_CFG2);
	wire sel_tx = (avs_address == `SCS_OFS_XMIT);
	wire sel_st = (avs_address == `SCS_OFS_STAT);
	wire sel_is = (avs_address == `SCS_OFS_ISD);
	wire fifo_in_ready;
	wire [17:0] fifo_out_data;
	wire fifo_out_valid;
	reg fifo_pop;
	wire busy;
	// One wait state per access; a write to a full FIFO is held off
	wire tx_stall = avs_write && sel_tx && !fifo_in_ready;
	assign avs_waitrequest = (avs_read || avs_write) && (!ack_r || tx_stall);
	wire wr_go = avs_write && !avs_waitrequest;
	wire rd_go = avs_read && !avs_waitrequest;
	// Byte-lane merge for configuration writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction
	// Acknowledge toggle and register writes
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ack_r <= 1'b0;
			cfg_r[0] <= `SCS_CFG_RST; // RULE15
			cfg_r[1] <= `SCS_CFG_RST; // RULE5
			isd_r <= 8'h00;
		end
		else
		begin
			ack_r <= (avs_read || avs_write) && !ack_r && !tx_stall;
			if (wr_go && sel_c1)
				cfg_r[0] <= merge(cfg_r[0], avs_writedata, avs_byteenable); // RULE15
			if (wr_go && sel_c2)
				cfg_r[1] <= merge(cfg_r[1], avs_writedata, avs_byteenable); // RULE15
			if (wr_go && sel_is && avs_byteenable[0])
				isd_r <= avs_writedata[7:0];
		end
	end
	// Read mux; unmapped addresses read zero
	always @(posedge core_clk)
	begin
		if (sys_rst)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !ack_r)
		begin
			avs_readdata <= 32'h00000000;
			if (sel_c1)
				avs_readdata <= cfg_r[0];
			if (sel_c2)
				avs_readdata <= cfg_r[1];
			if (sel_is)
				avs_readdata <= {24'h000000, isd_r};
			if (sel_st)
				avs_readdata <= {12'h000, fifo_out_valid, fifo_in_ready, busy, rx_new_r, rx_data_r};
		end
	end
	// Transmit FIFO: word is {select, 16-bit data}
	scs_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_data({1'b0, avs_writedata[16], avs_writedata[15:0]}),
		.in_valid(wr_go && sel_tx),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop)
	);
	// ******************************
	// Serial engine
	// ******************************
	localparam ST_IDLE = 3'd0;
	localparam ST_LEAD = 3'd1;
	localparam ST_SHIFT = 3'd2;
	localparam ST_GAP = 3'd3;
	localparam ST_REL = 3'd4;
	reg [2:0] st_r;
	reg cur_r;
	reg sel_on_r;
	reg [31:0] acfg_r;
	reg [15:0] sh_r;
	reg [4:0] bits_r;
	reg half_r;
	reg [12:0] cnt_r;
	reg [1:0] miso_sync_r;
	wire [7:0] f_ct = acfg_r[`SCS_F_CT_HI:`SCS_F_CT_LO];
	wire [7:0] f_pc = acfg_r[`SCS_F_PC_HI:`SCS_F_PC_LO];
	wire [7:0] f_bd = acfg_r[`SCS_F_BD_HI:`SCS_F_BD_LO];
	wire f_hold = acfg_r[`SCS_F_HOLD];
	wire f_frel = acfg_r[`SCS_F_FREL];
	wire f_pha = acfg_r[`SCS_F_PHA];
	wire f_pol = acfg_r[`SCS_F_POL];
	wire nxt_sel = fifo_out_data[16];
	wire [31:0] ncfg = cfg_r[nxt_sel]; // RULE16
	wire [3:0] nwd = ncfg[`SCS_F_WD_HI:`SCS_F_WD_LO];
	// Width code to bit count
	wire [4:0] nbits = (nwd <= `SCS_WD_LONG) ? (`SCS_WD_BASE8 + {1'b0, nwd}) : // RULE7
		(`SCS_WD_BASE4 + {1'b0, nwd} - {1'b0, `SCS_WD_SHORT});
	// Half serial period in module clocks, split so high+low equals divider
	wire [7:0] half_lo = {1'b0, f_bd[7:1]};
	wire [7:0] half_hi = f_bd - half_lo;
	wire [7:0] cur_half = half_r ? half_lo : half_hi;
	wire nxt_ok = fifo_out_valid;
	wire same_ok = nxt_ok && (nxt_sel == cur_r);
	assign busy = (st_r != ST_IDLE);
	// Left-justify data of any width into the shifter
	wire [15:0] load_sh = fifo_out_data[15:0] << (5'd16 - nbits);
	// Engine state machine
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st_r <= ST_IDLE;
			cur_r <= 1'b0;
			sel_on_r <= 1'b0;
			acfg_r <= `SCS_CFG_RST;
			sh_r <= 16'h0000;
			bits_r <= 5'd0;
			half_r <= 1'b0;
			cnt_r <= 13'd0;
			serial_clock <= 1'b0;
			mosi <= 1'b0;
			rx_data_r <= 16'h0000;
			rx_new_r <= 1'b0;
			fifo_pop <= 1'b0;
			miso_sync_r <= 2'b00;
			peripheral_select_line_n <= 2'b11;
		end
		else
		begin
			miso_sync_r <= {miso_sync_r[0], miso};
			fifo_pop <= 1'b0;
			if (rd_go && sel_st)
				rx_new_r <= 1'b0;
			case (st_r)
			ST_IDLE:
			begin
				if (!sel_on_r)
					serial_clock <= cfg_r[cur_r][`SCS_F_POL]; // RULE14
				if (nxt_ok && !fifo_pop && sel_on_r && nxt_sel != cur_r)
				begin
					// Held select goes up first; the new word starts on the next edge
					peripheral_select_line_n <= 2'b11; // RULE8
					sel_on_r <= 1'b0;
				end
				else if (nxt_ok && !fifo_pop)
				begin
					cur_r <= nxt_sel;
					acfg_r <= ncfg; // RULE16
					bits_r <= nbits;
					sh_r <= load_sh;
					mosi <= load_sh[15];
					fifo_pop <= 1'b1;
					half_r <= 1'b0;
					serial_clock <= ncfg[`SCS_F_POL]; // RULE14
					peripheral_select_line_n <= ~(2'b01 << nxt_sel);
					sel_on_r <= 1'b1;
					// Lead delay from select valid to first edge
					cnt_r <= (ncfg[`SCS_F_PC_HI:`SCS_F_PC_LO] == 8'h00) ? // RULE3
						{5'd0, ncfg[`SCS_F_BD_HI:`SCS_F_BD_LO] - {1'b0, ncfg[`SCS_F_BD_HI:`SCS_F_BD_LO+1]}} :
						{5'd0, ncfg[`SCS_F_PC_HI:`SCS_F_PC_LO]};
					st_r <= ST_LEAD;
				end
			end
			ST_LEAD:
			begin
				if (cnt_r <= 13'd1)
				begin
					// Lead time spent: this edge is already the first leading edge,
					// so select-to-edge equals the loaded lead count exactly
					serial_clock <= ~serial_clock; // RULE3
					half_r <= 1'b1;
					cnt_r <= {5'd0, half_lo};
					if (f_pha)
						rx_data_r <= {rx_data_r[14:0], miso_sync_r[1]}; // RULE12
					else
					begin
						// Leading edge puts the first bit out
						sh_r <= {sh_r[14:0], 1'b0}; // RULE13
						mosi <= sh_r[15];
					end
					st_r <= ST_SHIFT;
				end
				else
					cnt_r <= cnt_r - 1'b1;
			end
			ST_SHIFT:
			begin
				if (cnt_r <= 13'd1)
				begin
					// Divider counter terminal: toggle serial clock
					serial_clock <= ~serial_clock; // RULE4
					half_r <= ~half_r;
					cnt_r <= {5'd0, half_r ? half_hi : half_lo};
					if (!half_r)
					begin
						// Leading edge
						if (f_pha)
							rx_data_r <= {rx_data_r[14:0], miso_sync_r[1]}; // RULE12
						else
						begin
							// Present the next bit; the slave takes it on the trailing edge
							sh_r <= {sh_r[14:0], 1'b0}; // RULE13
							mosi <= sh_r[15];
						end
					end
					else
					begin
						// Trailing edge ends a bit
						if (f_pha)
						begin
							sh_r <= {sh_r[14:0], 1'b0}; // RULE12
							mosi <= sh_r[14];
						end
						else
							rx_data_r <= {rx_data_r[14:0], miso_sync_r[1]}; // RULE13
						bits_r <= bits_r - 1'b1;
						if (bits_r == 5'd1)
						begin
							rx_new_r <= 1'b1;
							if (f_ct != 8'h00)
							begin
								cnt_r <= {f_ct, `SCS_CT_MULT'd0}; // RULE1
								st_r <= ST_GAP;
							end
							else if (same_ok && !f_frel && !fifo_pop)
							begin
								// Back to back with no gap, clock stays even
								bits_r <= nbits; // RULE2
								sh_r <= load_sh;
								mosi <= load_sh[15];
								fifo_pop <= 1'b1;
								cnt_r <= {5'd0, half_hi};
							end
							else
							begin
								cnt_r <= 13'd1;
								st_r <= ST_GAP;
							end
						end
					end
				end
				else
					cnt_r <= cnt_r - 1'b1;
			end
			ST_GAP:
			begin
				if (cnt_r <= 13'd1)
				begin
					if (same_ok && !f_frel && !fifo_pop)
					begin
						// Select kept low while the next word is waiting
						bits_r <= nbits; // RULE10
						acfg_r <= ncfg;
						sh_r <= load_sh;
						mosi <= load_sh[15];
						fifo_pop <= 1'b1;
						cnt_r <= {5'd0, half_hi};
						half_r <= 1'b0;
						st_r <= ST_SHIFT;
					end
					else if (f_hold)
						st_r <= ST_IDLE; // RULE8
					else
					begin
						peripheral_select_line_n <= 2'b11; // RULE9
						sel_on_r <= 1'b0;
						// Release time, one extra when no consecutive delay
						cnt_r <= {5'd0, isd_r} + ((f_ct == 8'h00) ? 13'd1 : 13'd0); // RULE11
						st_r <= ST_REL;
					end
				end
				else
					cnt_r <= cnt_r - 1'b1;
			end
			ST_REL:
			begin
				if (cnt_r <= 13'd1)
					st_r <= ST_IDLE;
				else
					cnt_r <= cnt_r - 1'b1;
			end
			default:
				st_r <= ST_IDLE;
			endcase
		end
	end
endmodule

// file: core/scs_consts.vh
// Constants for the SPI chip-select timing block.
// Assumes inclusion by core/scs_spi.v only.
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH
// ******************************
// Register byte offsets
// ******************************
`define SCS_OFS_CFG1 8'h34
`define SCS_OFS_CFG2 8'h38
`define SCS_OFS_XMIT 8'h40
`define SCS_OFS_STAT 8'h44
`define SCS_OFS_ISD 8'h48
// ******************************
// Field positions in a configuration word
// ******************************
`define SCS_F_CT_HI 31
`define SCS_F_CT_LO 24
`define SCS_F_PC_HI 23
`define SCS_F_PC_LO 16
`define SCS_F_BD_HI 15
`define SCS_F_BD_LO 8
`define SCS_F_WD_HI 7
`define SCS_F_WD_LO 4
`define SCS_F_HOLD 3
`define SCS_F_FREL 2
`define SCS_F_PHA 1
`define SCS_F_POL 0
// ******************************
// Reset values, timing factors and width code constants
// ******************************
`define SCS_CFG_RST 32'h00000000
`define SCS_CT_MULT 5
`define SCS_WD_LONG 4'h8
`define SCS_WD_BASE8 5'h08
`define SCS_WD_BASE4 5'h04
`define SCS_WD_SHORT 4'h9
`endif

// file: core/scs_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module scs_fifo #(
	parameter WIDTH = 18,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire core_clk, // Clock
	input wire sys_rst, // Sync reset
	input wire [WIDTH-1:0] in_data, // Write data
	input wire in_valid, // Write request
	output wire in_ready, // Not full
	output wire [WIDTH-1:0] out_data, // Head word
	output wire out_valid, // Not empty
	input wire out_ready // Pop
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;
	// Flags and handshakes
	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data = mem[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage and pointers
	always @(posedge core_clk)
	begin
		if (push)
			mem[wp_r] <= in_data;
		if (sys_rst)
		begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// file: verification/scs_spi_monitor.sv
// Port checker for the SPI block: bus answers, select and serial clock timing.
// Assumes byte-lane config writes as the slave merges them, and one clock domain.
`timescale 1ns/1ps
module scs_spi_monitor (
	input wire core_clk, // Clock
	input wire sys_rst, // Reset
	input wire [7:0] avs_address, // Address
	input wire avs_read, // Read
	input wire avs_write, // Write
	input wire [31:0] avs_writedata, // Write data
	input wire [3:0] avs_byteenable, // Byte lanes
	input wire [31:0] avs_readdata, // Read data
	input wire avs_waitrequest, // Stall
	input wire serial_clock, // Serial clock
	input wire [1:0] peripheral_select_line_n // Selects
);
	reg [31:0] cfg_r [0:1];
	reg [7:0] isd_r;
	reg [8:0] cnt_r;
	reg [8:0] hi_r;
	reg [1:0] ls_r;
	reg sc_r;
	reg low_r;
	reg edge_r;
	integer k;
	wire low = peripheral_select_line_n != 2'h3;
	wire [31:0] c = cfg_r[peripheral_select_line_n[0]];
	wire [8:0] dv = {1'b0, c[15:8]};
	wire chg = serial_clock != sc_r;
	wire act = chg && (edge_r || serial_clock != c[0]);
	wire [8:0] pre = (c[23:16] != 8'h00) ? {1'b0, c[23:16]} : (dv + 9'h001) >> 1;
	wire acc = avs_write && !avs_waitrequest;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Shadow config words; count cycles since the last select fall or clock edge
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cfg_r[0] <= 32'h0;
			cfg_r[1] <= 32'h0;
			isd_r <= 8'h00;
			cnt_r <= 9'h000;
			hi_r <= 9'h000;
			ls_r <= 2'h3;
			sc_r <= 1'b0;
			low_r <= 1'b0;
			edge_r <= 1'b0;
		end
		else
		begin
			for (k = 0; k < 4; k = k + 1)
			begin
				if (acc && avs_byteenable[k] && avs_address == 8'h34)
					cfg_r[0][k*8 +: 8] <= avs_writedata[k*8 +: 8];
				if (acc && avs_byteenable[k] && avs_address == 8'h38)
					cfg_r[1][k*8 +: 8] <= avs_writedata[k*8 +: 8];
			end
			if (acc && avs_byteenable[0] && avs_address == 8'h48)
				isd_r <= avs_writedata[7:0];
			cnt_r <= (low && (!low_r || act)) ? 9'h001 : cnt_r + 9'h001;
			hi_r <= low ? 9'h000 : hi_r + {8'h00, ~&hi_r};
			ls_r <= low ? peripheral_select_line_n : ls_r;
			sc_r <= serial_clock;
			low_r <= low;
			edge_r <= low && (edge_r || act);
		end
	end
	bus_answer_a: assert property ($rose(avs_read || avs_write) && avs_address != 8'h40 |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait state");
	cfg_readback_a: assert property (avs_read && !avs_waitrequest && (avs_address == 8'h34 || avs_address == 8'h38)
		|-> avs_readdata == cfg_r[avs_address[3]]) else $error("config readback wrong");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && !(avs_address inside {8'h34, 8'h38, 8'h40, 8'h44, 8'h48})
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	one_select_a: assert property (peripheral_select_line_n != 2'h0)
		else $error("both selects low");
	pre_clock_a: assert property (low && act && !edge_r |-> cnt_r == pre)
		else $error("select to first edge wrong");
	// Active phase (away from idle level) lasts floor(div/2), idle phase ceil(div/2)
	half_period_a: assert property (low && act && edge_r && c[31:24] == 8'h00
		|-> cnt_r == ((sc_r != c[0]) ? dv >> 1 : (dv + 9'h001) >> 1)) else $error("serial clock half period wrong");
	idle_level_a: assert property ($rose(&peripheral_select_line_n) |-> serial_clock == $past(c[0]))
		else $error("serial clock not at idle level");
	release_gap_a: assert property (low && !low_r && peripheral_select_line_n == ls_r && c[2] && !c[3]
		|-> hi_r >= {1'b0, isd_r} + (c[31:24] == 8'h00)) else $error("forced release too short");
	cover property (low && !low_r && c[0]);
	cover property (low && !low_r && c[2] && peripheral_select_line_n == ls_r);
	cover property (low && act && edge_r && c[31:24] != 8'h00);
endmodule

// file: verification/scs_slave_model.sv
// Far-side SPI slave: shifts in mosi on its capture edge and drives miso.
// Assumes the bench gives it the mode of the active select.
`timescale 1ns/1ps
module scs_slave_model (
	input wire sclk, // Serial clock
	input wire sel_n, // Any select, low active
	input wire pol, // Idle level
	input wire pha, // Phase bit
	input wire mosi, // Data from master
	output reg miso, // Data to master
	output reg [15:0] rx, // Captured bits
	output reg [4:0] nbits // Bit count
);
	reg [15:0] tx;
	// Frame start: clear capture, present first bit early when capturing on leading edge
	always @(negedge sel_n)
	begin
		rx = 16'h0000;
		nbits = 5'h00;
		tx = 16'hC3A5;
		miso = tx[15];
		if (pha)
			tx = {tx[14:0], 1'b0};
	end
	// Released line does not keep its last value
	always @(posedge sel_n)
		miso = ~miso;
	// Leading edge leaves the idle level; phase bit picks the capture edge
	always @(sclk)
		if (!sel_n && ((sclk != pol) == pha))
		begin
			rx = {rx[14:0], mosi};
			nbits = nbits + 5'h01;
		end
		else if (!sel_n)
		begin
			miso = tx[15];
			tx = {tx[14:0], 1'b0};
		end
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the SPI block with slave model and bound checker.
// Assumes core/ files compiled first with core/ on the include path.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks = total_checks + 1; if ((a) !== (b)) begin miscompares = miscompares + 1; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] avs_address = 8'h00;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h0;
	reg [3:0] avs_byteenable = 4'hF;
	reg pol = 1'b0;
	reg pha = 1'b0;
	reg [31:0] rd;
	reg [31:0] d;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire serial_clock;
	wire mosi;
	wire miso;
	wire [1:0] sel_n;
	wire [15:0] rx;
	wire [4:0] nbits;
	integer miscompares = 0;
	integer total_checks = 0;
	integer regm [0:1];
	integer i, n, t0, wt;
	integer lowc = 0;
	integer rises = 0;
	scs_spi scs_spi_i (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_clock(serial_clock), .mosi(mosi), .miso(miso),
		.peripheral_select_line_n(sel_n));
	scs_slave_model scs_slave_model_i (.sclk(serial_clock), .sel_n(&sel_n), .pol(pol), .pha(pha), .mosi(mosi),
		.miso(miso), .rx(rx), .nbits(nbits));
	// Clock and select 1 activity counters
	initial
		forever #2.5 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (sel_n[0] === 1'b0)
			lowc = lowc + 1;
	always @(posedge sel_n[0])
		rises = rises + 1;
	// Verdict and end of run
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, miscompares);
			if (miscompares == 0 && total_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task fail;
		begin
			miscompares = miscompares + 1;
			$display("ERROR %0t wait limit reached", $time);
			end_of_test;
		end
	endtask
	// One bus cycle held until waitrequest is seen low at a rising edge
	task bus(input w, input [7:0] a, input [31:0] v);
		integer k;
		begin
			avs_address <= a;
			avs_writedata <= v;
			avs_read <= !w;
			avs_write <= w;
			k = 0;
			@(posedge core_clk);
			while (avs_waitrequest !== 1'b0)
			begin
				k = k + 1;
				if (k > 20000)
					fail;
				@(posedge core_clk);
			end
			rd = avs_readdata;
			wt = k;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task cfg(input integer x, input [31:0] w);
		begin
			regm[x] = w;
			bus(1'b1, x ? 8'h38 : 8'h34, w);
		end
	endtask
	task send(input x, input [15:0] v);
		bus(1'b1, 8'h40, {15'h0000, x, v});
	endtask
	// Poll status until the engine is idle and the queue empty
	task done;
		integer k;
		begin
			k = 0;
			rd = 32'hFFFFFFFF;
			while ((rd[17] | rd[19]) !== 1'b0)
			begin
				bus(1'b0, 8'h44, 32'h0);
				k = k + 1;
				if (k > 9000)
					fail;
			end
		end
	endtask
	initial
	begin
		i = $urandom(32'h7EEA);
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		// Reset values and an unmapped place read as zero
		for (i = 0; i < 4; i = i + 1)
		begin
			bus(1'b0, (i == 3) ? 8'h48 : 8'h34 + {4'h0, i[1:0], 2'b00}, 32'h0);
			`CHK(rd, 32'h0)
		end
		// Random words read back from both config places
		for (i = 0; i < 2; i = i + 1)
		begin
			cfg(i, $urandom);
			bus(1'b0, i ? 8'h38 : 8'h34, 32'h0);
			`CHK(rd, regm[i])
		end
		// One byte lane only: the other lanes keep their value
		avs_byteenable <= 4'h2;
		bus(1'b1, 8'h34, ~regm[0]);
		avs_byteenable <= 4'hF;
		bus(1'b0, 8'h34, 32'h0);
		`CHK(rd, {regm[0][31:16], ~regm[0][15:8], regm[0][7:0]})
		bus(1'b1, 8'h48, 32'h3);
		// Width codes 0 to 12, then all four clock modes at sixteen bits
		for (i = 0; i < 17; i = i + 1)
		begin
			n = (i < 13) ? i : 8;
			pol <= i[0];
			pha <= i[1];
			d = $urandom;
			cfg(0, {24'h000002, n[3:0], 2'b00, i[1], i[0]});
			send(0, d[15:0]);
			done;
			`CHK(nbits, (n < 9) ? n + 8 : n - 5)
			if (n == 8)
				`CHK(rx, d[15:0])
			`CHK(serial_clock, i[0])
			`CHK(sel_n, 2'h3)
		end
		// Two queued words on select 1, without and with forced release
		pol <= 1'b0;
		pha <= 1'b0;
		for (i = 0; i < 2; i = i + 1)
		begin
			cfg(0, {24'h000002, 5'h10, i[0], 2'b00});
			rises = 0;
			send(0, d[15:0]);
			send(0, d[15:0]);
			done;
			`CHK(rises, i + 1)
		end
		// Held select, then a switch to select 2 with its own width
		cfg(0, {24'h000002, 8'h88});
		cfg(1, {24'h000002, 8'h90});
		send(0, d[15:0]);
		done;
		`CHK(sel_n, 2'h2)
		send(1, d[15:0]);
		done;
		`CHK(sel_n, 2'h3)
		`CHK(nbits, 4)
		// Same word without and with a consecutive-transfer delay of 2
		for (i = 0; i < 2; i = i + 1)
		begin
			cfg(0, {6'h00, i[0], 17'h00503, 8'h80});
			lowc = 0;
			send(0, d[15:0]);
			done;
			if (i == 0)
				t0 = lowc;
		end
		// Zero delay still releases one cycle after the last edge, so the gap adds 32*2-1
		`CHK(lowc - t0, 32 * 2 - 1)
		// Fill the queue until a write stalls, then drain it
		cfg(1, {24'h000014, 8'h80});
		for (i = 0; i < 18; i = i + 1)
			send(1, d[15:0]);
		`CHK(wt > 0, 1'b1)
		bus(1'b0, 8'h44, 32'h0);
		`CHK(rd[18], 1'b0)
		done;
		end_of_test;
	end
endmodule
// Port checker on the SPI block
bind scs_spi scs_spi_monitor scs_spi_monitor_i (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .serial_clock(serial_clock),
	.peripheral_select_line_n(peripheral_select_line_n));
